// ### common/por_seq_defs.svh
// constants for the power-on reset sequencer
// Overview of operation
// - hold reset until supply passes rise threshold
// - assert reset when supply below fall threshold
// - power-on reset clears all cause flags
// - internal resets set own flag, keep others
// - first pin release: longest processing interval
// - later pin releases: shorter processing interval
// - interval covers oscillator accuracy settling
// - drop interrupt in interrupt-and-reset mode sets level and mode bits
// - stabilise and finish power-on before detector
// - detector processing ends within 0.0701 ms
// - detector-only reset recovery takes 0.0511 ms
// - interrupt mode starts like reset mode
// - pin low resets, pin high releases
// - pin, power-on or read clears causes
`ifndef POR_SEQ_DEFS_SVH
`define POR_SEQ_DEFS_SVH
`define CLK_NS 8
`define T_STAB_NS 990000
`define T_FIRST_LVD_NS 832000
`define T_FIRST_OFF_NS 519000
`define T_OTHER_LVD_NS 675000
`define T_OTHER_OFF_NS 362000
`define T_LVD_PROC_NS 51100
`define CNT_W 17
`define ADDR_CAUSE 4'h0
`define ADDR_LEVEL 4'h1
`define ADDR_STAT 4'h2
`define ADDR_CLR 4'h3
`define ADDR_EN 4'h4
`define ADDR_STATE 4'h5
`define CAUSE_TRAP 7
`define CAUSE_WDOG 4
`define CAUSE_PAR 2
`define CAUSE_ACC 1
`define CAUSE_LV 0
`define LEVEL_MODE_BIT 7
`define LEVEL_SEL_BIT 0
`define STAT_LVIRQ 0
`define STAT_DONE 1
`define MODE_OFF 2'b00
`define MODE_INT 2'b01
`define MODE_INTRST 2'b10
`define MODE_RST 2'b11
`endif

// ### common/por_seq_pkg.sv
// types shared by the power-on reset sequencer
package por_seq_pkg;
    typedef enum logic [2:0] {
        ST_POR, ST_STAB, ST_PIN, ST_PROC, ST_LVD_HOLD, ST_LVD_PROC, ST_RUN
    } seq_state_type;
    typedef struct packed {
        logic pin_n;
        logic rise_ok;
        logic fall_below;
        logic below_high;
        logic below_low;
        logic opt_hi;
        logic opt_lo;
    } pins_type;
    typedef struct packed {
        logic watchdog;
        logic trap;
        logic parity;
        logic bad_access;
    } int_src_type;
endpackage

// ### rtl/power_on_reset_sequencer.sv
// reset sequencer: supply comparators, pin reset, cause flags, drop detector
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "por_seq_defs.svh"
module power_on_reset_sequencer
    import por_seq_pkg::*;
#(
    parameter int STAB_CYC = `T_STAB_NS / `CLK_NS,
    parameter int FIRST_LVD_CYC = `T_FIRST_LVD_NS / `CLK_NS,
    parameter int FIRST_OFF_CYC = `T_FIRST_OFF_NS / `CLK_NS,
    parameter int OTHER_LVD_CYC = `T_OTHER_LVD_NS / `CLK_NS,
    parameter int OTHER_OFF_CYC = `T_OTHER_OFF_NS / `CLK_NS,
    parameter int LVD_PROC_CYC = `T_LVD_PROC_NS / `CLK_NS
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire pins_type pins_i,
    input wire int_src_type int_src_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic sys_reset_o,
    output logic low_voltage_irq_o,
    output logic irq_o
);
    typedef struct packed {
        pins_type s1;
        pins_type s2;
        seq_state_type st;
        logic [`CNT_W-1:0] cnt;
        logic first;
        logic armed;
        logic [7:0] reset_cause_flags;
        logic detect_mode_select;
        logic detect_level_select;
        logic [1:0] stat;
        logic [1:0] en;
        logic prev_high;
        logic [7:0] rdata;
        logic rst;
        logic lvirq;
        logic irq;
    } regs_type;

    regs_type q;
    regs_type d;

    function automatic logic [1:0] mode_of(input pins_type p);
        return {p.opt_hi, p.opt_lo};
    endfunction

    function automatic logic [`CNT_W-1:0] cyc(input int n);
        // never less than one cycle
        return (n < 1) ? `CNT_W'(1) : `CNT_W'(n);
    endfunction

    logic [1:0] mode;
    logic lvd_on;
    logic lvd_trip;
    logic drop_evt;
    logic rise_evt;
    logic cause_rd;

    always_comb begin
        d = q;
        d.s1 = pins_i;
        d.s2 = q.s1;
        mode = mode_of(q.s2);
        lvd_on = (mode != `MODE_OFF);
        rise_evt = q.prev_high & ~q.s2.below_high;
        drop_evt = ~q.prev_high & q.s2.below_high;
        d.prev_high = q.s2.below_high;
        cause_rd = rd_i && (addr_i == `ADDR_CAUSE);
        d.lvirq = 1'b0;
        // detector reset trigger depends on mode
        unique case (mode)
            `MODE_INTRST: lvd_trip = q.s2.below_low;
            `MODE_RST: lvd_trip = q.s2.below_high;
            // interrupt mode resets only until first release
            `MODE_INT: lvd_trip = q.armed & q.s2.below_high;
            default: lvd_trip = 1'b0;
        endcase

        // read data, one cycle later
        unique case (addr_i)
            `ADDR_CAUSE: d.rdata = q.reset_cause_flags;
            `ADDR_LEVEL: d.rdata = {q.detect_mode_select, 6'h00, q.detect_level_select};
            `ADDR_STAT: d.rdata = {6'h00, q.stat};
            `ADDR_EN: d.rdata = {6'h00, q.en};
            `ADDR_STATE: d.rdata = {q.first, q.armed, q.s2.below_high, 2'b00, q.st};
            default: d.rdata = 8'h00;
        endcase
        if (!rd_i) begin
            d.rdata = 8'h00;
        end
        // reading the cause register clears it
        if (cause_rd) begin
            d.reset_cause_flags = 8'h00;
        end
        if (wr_i && addr_i == `ADDR_EN) begin
            d.en = wdata_i[1:0];
        end
        if (wr_i && addr_i == `ADDR_CLR) begin
            d.stat = q.stat & ~wdata_i[1:0];
        end
        // software may lower the bits only in interrupt-and-reset mode
        if (wr_i && addr_i == `ADDR_LEVEL && mode == `MODE_INTRST) begin
            d.detect_mode_select = wdata_i[`LEVEL_MODE_BIT];
            d.detect_level_select = wdata_i[`LEVEL_SEL_BIT];
        end

        // drop detector interrupts while running
        if (q.st == ST_RUN) begin
            if (mode == `MODE_INTRST && drop_evt) begin
                d.lvirq = 1'b1;
                // level and mode bits go to one
                d.detect_mode_select = 1'b1;
                d.detect_level_select = 1'b1;
            end
            if (mode == `MODE_INT && (drop_evt || rise_evt)) begin
                d.lvirq = 1'b1;
            end
        end
        // set wins over a same-cycle clear
        if (d.lvirq) begin
            d.stat[`STAT_LVIRQ] = 1'b1;
        end

        unique case (q.st)
            ST_POR: begin
                if (q.s2.rise_ok) begin
                    d.st = ST_STAB;
                    d.cnt = cyc(STAB_CYC);
                end
            end
            ST_STAB: begin
                if (q.cnt > `CNT_W'(1)) begin
                    d.cnt = q.cnt - `CNT_W'(1);
                end else if (q.s2.pin_n) begin
                    d.st = ST_PROC;
                    d.first = 1'b0;
                    d.cnt = lvd_on ? cyc(FIRST_LVD_CYC) : cyc(FIRST_OFF_CYC);
                end else begin
                    d.st = ST_PIN;
                end
            end
            ST_PIN: begin
                // high level on the pin releases
                if (q.s2.pin_n) begin
                    d.st = ST_PROC;
                    d.first = 1'b0;
                    if (q.first) begin
                        d.cnt = lvd_on ? cyc(FIRST_LVD_CYC) : cyc(FIRST_OFF_CYC);
                    end else begin
                        d.cnt = lvd_on ? cyc(OTHER_LVD_CYC) : cyc(OTHER_OFF_CYC);
                    end
                end
            end
            ST_PROC: begin
                if (q.cnt > `CNT_W'(1)) begin
                    d.cnt = q.cnt - `CNT_W'(1);
                end else if (lvd_on && q.s2.below_high && (mode != `MODE_INT || q.armed)) begin
                    d.st = ST_LVD_HOLD;
                end else begin
                    d.st = ST_RUN;
                    d.armed = 1'b0;
                    d.stat[`STAT_DONE] = 1'b1;
                end
            end
            ST_LVD_HOLD: begin
                // release once above the high or single level
                if (!q.s2.below_high) begin
                    d.st = ST_LVD_PROC;
                    d.cnt = cyc(LVD_PROC_CYC);
                end
            end
            ST_LVD_PROC: begin
                if (q.cnt > `CNT_W'(1)) begin
                    d.cnt = q.cnt - `CNT_W'(1);
                end else begin
                    d.st = ST_RUN;
                    d.armed = 1'b0;
                    d.stat[`STAT_DONE] = 1'b1;
                end
            end
            ST_RUN: begin
                // internal sources set own flag, others held
                if (lvd_trip) begin
                    d.reset_cause_flags[`CAUSE_LV] = 1'b1;
                    d.st = ST_LVD_HOLD;
                end
                if (|int_src_i) begin
                    d.reset_cause_flags[`CAUSE_WDOG] = q.reset_cause_flags[`CAUSE_WDOG]
                        | int_src_i.watchdog;
                    d.reset_cause_flags[`CAUSE_TRAP] = q.reset_cause_flags[`CAUSE_TRAP]
                        | int_src_i.trap;
                    d.reset_cause_flags[`CAUSE_PAR] = q.reset_cause_flags[`CAUSE_PAR]
                        | int_src_i.parity;
                    d.reset_cause_flags[`CAUSE_ACC] = q.reset_cause_flags[`CAUSE_ACC]
                        | int_src_i.bad_access;
                    if (!lvd_trip) begin
                        d.st = ST_LVD_PROC;
                        d.cnt = cyc(LVD_PROC_CYC);
                    end
                end
            end
            default: d.st = ST_POR;
        endcase

        // pin low puts the chip in reset from any state except ST_POR and ST_STAB
        if (!q.s2.pin_n && q.st != ST_POR && q.st != ST_STAB) begin
            d.st = ST_PIN;
            d.reset_cause_flags = 8'h00;
        end
        // supply below fall threshold, or not yet risen
        if (q.s2.fall_below || !q.s2.rise_ok) begin
            d.st = ST_POR;
            d.first = 1'b1;
            d.armed = 1'b1;
            d.reset_cause_flags = 8'h00;
        end
        // power-on and pin resets reload the level bits per mode
        if (d.st == ST_POR || d.st == ST_PIN) begin
            d.detect_mode_select = (mode == `MODE_RST);
            d.detect_level_select = (mode == `MODE_RST) || (mode == `MODE_INT);
        end
        // reset while any source or interval is active
        d.rst = (d.st != ST_RUN);
        d.irq = |(d.stat & d.en);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '{
                s1: '0,
                s2: '0,
                st: ST_POR,
                cnt: '0,
                first: 1'b1,
                armed: 1'b1,
                reset_cause_flags: 8'h00,
                detect_mode_select: 1'b0,
                detect_level_select: 1'b0,
                stat: 2'b00,
                en: 2'b00,
                prev_high: 1'b0,
                rdata: 8'h00,
                rst: 1'b1,
                lvirq: 1'b0,
                irq: 1'b0
            };
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign sys_reset_o = q.rst;
    assign low_voltage_irq_o = q.lvirq;
    assign irq_o = q.irq;
endmodule

// ### sim/por_seq_assertions.sv
// port-level checks for the power-on reset sequencer
`timescale 1ns/1ps
module por_seq_assertions
    import por_seq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire pins_type pins_i,
    input wire int_src_type int_src_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic sys_reset_o,
    input wire logic low_voltage_irq_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // inputs pass two sync flops, so six cycles is a safe settle
    property p_rise;
        !pins_i.rise_ok [*6] |-> sys_reset_o;
    endproperty
    property p_run;
        !sys_reset_o |-> $past(pins_i.rise_ok, 4);
    endproperty
    property p_fall;
        pins_i.fall_below [*6] |-> sys_reset_o;
    endproperty
    property p_pin;
        !pins_i.pin_n [*6] |-> sys_reset_o;
    endproperty
    property p_fell;
        $fell(sys_reset_o) |-> $past(pins_i.pin_n, 4) && pins_i.rise_ok;
    endproperty
    property p_hold;
        $rose(pins_i.pin_n) && sys_reset_o |-> sys_reset_o [*7];
    endproperty
    property p_max;
        $rose(pins_i.pin_n) && pins_i.rise_ok && !pins_i.below_high
            |-> ##[1:60] !sys_reset_o;
    endproperty
    property p_src;
        int_src_i != '0 && !sys_reset_o |-> ##[1:3] sys_reset_o;
    endproperty
    property p_clr;
        (rd_i && addr_i == 4'h0 && int_src_i == '0) ##1 (!rd_i && int_src_i == '0)
            ##1 (rd_i && addr_i == 4'h0 && int_src_i == '0) |=> rdata_o == 8'h00;
    endproperty
    property p_pulse;
        low_voltage_irq_o |=> !low_voltage_irq_o;
    endproperty
    a_rise: assert property (p_rise) else $error("reset low with supply low");
    a_run: assert property (p_run) else $error("running after supply loss");
    a_fall: assert property (p_fall) else $error("no reset on supply fall");
    a_pin: assert property (p_pin) else $error("no reset on pin low");
    a_fell: assert property (p_fell) else $error("reset released too early");
    a_hold: assert property (p_hold) else $error("pin release interval short");
    a_max: assert property (p_max) else $error("pin release interval long");
    a_src: assert property (p_src) else $error("internal source ignored");
    a_clr: assert property (p_clr) else $error("cause read did not clear");
    a_pulse: assert property (p_pulse) else $error("drop irq not a pulse");
    c_rel: cover property ($fell(sys_reset_o));
    c_lv: cover property (low_voltage_irq_o);
    c_irq: cover property ($rose(irq_o));
endmodule
bind power_on_reset_sequencer por_seq_assertions u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .pins_i(pins_i), .int_src_i(int_src_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sys_reset_o(sys_reset_o), .low_voltage_irq_o(low_voltage_irq_o), .irq_o(irq_o));

// ### sim/cpu_model.sv
// core and peripherals that receive the internal reset
`timescale 1ns/1ps
module cpu_model
    import por_seq_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_reset_i,
    input wire int_src_type fire_i,
    output int_src_type int_src_o
);
    // sources fire only while core runs
    always_ff @(posedge clk_i) begin
        int_src_o <= sys_reset_i ? '0 : fire_i;
    end
endmodule

// ### sim/tb.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
`include "por_seq_defs.svh"
module tb
    import por_seq_pkg::*;
;
    logic clk, rstn, wr, rd, sys_rst, lvirq, irq;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, exp_c;
    logic [7:0] cmap [4] = '{8'h02, 8'h04, 8'h80, 8'h10};
    pins_type pins;
    int_src_type fire, src;
    int err_total, cmp_count, n;
    // short counts keep the run small
    power_on_reset_sequencer #(.STAB_CYC(8), .FIRST_LVD_CYC(12), .FIRST_OFF_CYC(10),
        .OTHER_LVD_CYC(9), .OTHER_OFF_CYC(7), .LVD_PROC_CYC(5)) dut (
        .clk_i(clk), .rstn_i(rstn), .pins_i(pins), .int_src_i(src), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sys_reset_o(sys_rst),
        .low_voltage_irq_o(lvirq), .irq_o(irq));
    cpu_model u_cpu (.clk_i(clk), .sys_reset_i(sys_rst), .fire_i(fire), .int_src_o(src));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rng(string nm, int lo);
        chk(nm, 8'(n >= lo && n <= lo + 8), 8'h01);
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_rel();
        n = 0;
        while (sys_rst !== 1'b0 && n < 300) begin
            tick(1);
            n++;
        end
    endtask
    task automatic rd_reg(logic [3:0] a, logic [7:0] e, string nm);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, rdata, e);
    endtask
    task automatic wr_reg(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        tick(2);
    endtask
    task automatic pin_pulse();
        @(posedge clk);
        pins.pin_n <= 1'b0;
        tick(10);
        chk("pin_reset", sys_rst, 1'b1);
        @(posedge clk);
        pins.pin_n <= 1'b1;
        wait_rel();
    endtask
    task automatic fire_src(int_src_type s);
        @(posedge clk);
        fire <= s;
        @(posedge clk);
        fire <= '0;
        tick(3);
        chk("src_reset", sys_rst, 1'b1);
        wait_rel();
        n = n + 4;
    endtask
    initial begin
        #80000;
        err_total++;
        test_done();
    end
    initial begin
        err_total = 0;
        cmp_count = 0;
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        fire = '0;
        pins = '{pin_n: 1'b1, rise_ok: 1'b0, fall_below: 1'b0, below_high: 1'b0,
                 below_low: 1'b0, opt_hi: 1'b1, opt_lo: 1'b1};
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        tick(20);
        chk("por_hold", sys_rst, 1'b1);
        @(posedge clk);
        pins.rise_ok <= 1'b1;
        wait_rel();
        rng("first_rel", 20);
        rd_reg(`ADDR_CAUSE, 8'h00, "cause_por");
        pin_pulse();
        rng("other_rel", 9);
        exp_c = 8'h00;
        for (int i = 0; i < 4; i++) begin
            fire_src(int_src_type'(4'h1 << i));
            exp_c |= cmap[i];
            rng("src_rel", 5);
        end
        rd_reg(`ADDR_CAUSE, exp_c, "cause_set");
        rd_reg(`ADDR_CAUSE, 8'h00, "cause_rd_clr");
        wr_reg(`ADDR_CAUSE, 8'h_ff);
        rd_reg(`ADDR_CAUSE, 8'h00, "cause_ro");
        rd_reg(4'hf, 8'h00, "unmapped");
        // interrupt-and-reset straps act after the sync flops; the pin reset reloads the level bits
        fire_src(int_src_type'(4'h8));
        @(posedge clk);
        pins.opt_lo <= 1'b0;
        pin_pulse();
        rd_reg(`ADDR_CAUSE, 8'h00, "cause_pin");
        rd_reg(`ADDR_LEVEL, 8'h00, "level_reload");
        wr_reg(`ADDR_EN, 8'h01);
        @(posedge clk);
        pins.below_high <= 1'b1;
        n = 0;
        while (lvirq !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk("lv_irq", lvirq, 1'b1);
        rd_reg(`ADDR_LEVEL, 8'h81, "level_auto");
        chk("irq_on", irq, 1'b1);
        wr_reg(`ADDR_EN, 8'h00);
        chk("irq_mask", irq, 1'b0);
        wr_reg(`ADDR_EN, 8'h01);
        chk("irq_unmask", irq, 1'b1);
        wr_reg(`ADDR_CLR, 8'h01);
        chk("irq_clear", irq, 1'b0);
        // low level trips the detector reset in this mode
        @(posedge clk);
        pins.below_low <= 1'b1;
        tick(5);
        chk("lv_reset", sys_rst, 1'b1);
        @(posedge clk);
        pins.below_low <= 1'b0;
        pins.below_high <= 1'b0;
        wait_rel();
        rd_reg(`ADDR_CAUSE, 8'h01, "cause_lv");
        fire_src(int_src_type'(4'h8));
        @(posedge clk);
        pins.fall_below <= 1'b1;
        tick(8);
        chk("fall_reset", sys_rst, 1'b1);
        rd_reg(`ADDR_CAUSE, 8'h00, "cause_fall");
        // detector off: pin held low across power-up
        @(posedge clk);
        pins.fall_below <= 1'b0;
        pins.opt_hi <= 1'b0;
        pins.pin_n <= 1'b0;
        tick(20);
        chk("off_hold", sys_rst, 1'b1);
        @(posedge clk);
        pins.pin_n <= 1'b1;
        wait_rel();
        rng("off_rel", 10);
        rd_reg(`ADDR_LEVEL, 8'h00, "level_off");
        test_done();
    end
endmodule
